// >>> dv/csi_host_model.sv
// Host register master model driving the status and indicator register port
`timescale 1ns/10ps
module csi_host_model
    import csi_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register port
    output csi_reg_req_s reg_req,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_req = '0;
    end

    // Released lines do not keep the last value
    task automatic idle_bus();
        reg_req.wr = 1'b0;
        reg_req.rd = 1'b0;
        reg_req.addr = ~reg_req.addr;
        reg_req.wdata = ~reg_req.wdata;
    endtask : idle_bus

    // Entered and left just after a rising edge; hold keeps the strobe up for a back-to-back write
    task automatic write(input logic [7:0] addr, input logic [7:0] data, input bit hold);
        reg_req.wr = 1'b1;
        reg_req.rd = 1'b0;
        reg_req.addr = addr;
        reg_req.wdata = data;
        @(posedge clk);
        #1;
        if (!hold) begin
            idle_bus();
        end
    endtask : write

    // Read data is registered, so it is taken one edge after the strobe
    task automatic read(input logic [7:0] addr, output logic [7:0] data);
        reg_req.wr = 1'b0;
        reg_req.rd = 1'b1;
        reg_req.addr = addr;
        @(posedge clk);
        #1;
        idle_bus();
        @(posedge clk);
        #1;
        data = reg_rdata;
    endtask : read

    // Software waits for the reset bit to drop before touching the channel again
    task automatic wait_reset_done(output bit done);
        logic [7:0] v;
        done = 1'b0;
        for (int i = 0; i < 8 && !done; i++) begin
            read(CSI_CHAN_B_STATUS_ADDR, v);
            done = (v[CSI_BIT_SOFT_RESET] === 1'b0);
        end
    endtask : wait_reset_done
endmodule : csi_host_model

// >>> dv/csi_status_indicator_tb.sv
// Self-checking testbench for the status and indicator register block
`timescale 1ns/10ps
module csi_status_indicator_tb
    import csi_pkg::*;
;
    logic clk;
    logic rstn;
    logic clk_en;
    csi_reg_req_s reg_req;
    logic [7:0] reg_rdata;
    logic [2:0] raw;
    csi_rx_status_s rx_status;
    logic engine_on;
    logic queue_flush;
    logic soft_reset;
    logic status_irq;
    csi_pins_s pins;
    int num_errors = 0;
    int check_count = 0;

    csi_status_indicator dut_u (
        .clk(clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .chan_b_supply_overcurrent_raw(raw[CSI_FLAG_OVERCURRENT]),
        .chan_b_supply_undervolt_raw(raw[CSI_FLAG_UNDERVOLT]),
        .chan_b_line_fault_raw(raw[CSI_FLAG_LINE_FAULT]),
        .rx_status(rx_status),
        .chan_b_message_engine_on(engine_on),
        .chan_b_queue_flush(queue_flush),
        .chan_b_soft_reset(soft_reset),
        .global_status_irq(status_irq),
        .pins(pins)
    );

    csi_host_model host_u (
        .clk(clk),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        if (num_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic test_reset_values();
        logic [7:0] v;
        check({4'h0, status_irq, engine_on, queue_flush, soft_reset}, 8'h00);
        check(8'(pins), 8'h00);
        host_u.write(8'h0f, 8'hff, 1'b1);
        host_u.read(CSI_CHAN_B_STATUS_ADDR, v);
        check(v, 8'h00);
        host_u.read(CSI_INDICATOR_ADDR, v);
        check(v, CSI_INDICATOR_RESET);
        host_u.read(8'h0f, v);
        check(v, CSI_UNMAPPED_READ);
    endtask : test_reset_values

    // Every select and lamp combination, with receive status varied alongside
    task automatic test_pins();
        logic [7:0] d;
        logic [7:0] v;
        logic [3:0] exp;
        for (int k = 0; k < 256; k++) begin
            d = 8'(k);
            rx_status = csi_rx_status_s'(d[3:0] ^ d[7:4]);
            host_u.write(CSI_INDICATOR_ADDR, d, 1'b0);
            tick(2);
            exp[3] = d[6] ? rx_status.chan_b_receive_fault_status : d[7];
            exp[2] = d[4] ? rx_status.chan_b_receive_data_ready_status : d[5];
            exp[1] = d[2] ? rx_status.chan_a_receive_fault_status : d[3];
            exp[0] = d[0] ? rx_status.chan_a_receive_data_ready_status : d[1];
            check(8'(pins), 8'(exp));
            host_u.read(CSI_INDICATOR_ADDR, v);
            check(v, d);
        end
    endtask : test_pins

    // Each fault flag, then all three at once, with the engine bit on
    task automatic test_flags();
        logic [7:0] v;
        logic [2:0] f;
        host_u.write(CSI_CHAN_B_STATUS_ADDR, 8'h7f, 1'b0);
        check(8'(engine_on), 8'h01);
        for (int i = 0; i < 4; i++) begin
            f = (i == 3) ? 3'h7 : 3'(1 << i);
            raw = f;
            tick(5);
            check(8'(status_irq), 8'h01);
            host_u.read(CSI_CHAN_B_STATUS_ADDR, v);
            check(v, 8'h40 | (8'(f) << 3) | 8'(f));
            host_u.read(CSI_CHAN_B_STATUS_ADDR, v);
            check(v, 8'h40 | 8'(f));
            check(8'(status_irq), 8'h00);
            raw = 3'h0;
            tick(5);
            host_u.read(CSI_CHAN_B_STATUS_ADDR, v);
            check(v, 8'h40);
        end
        // A flag rising in the cycle of a read survives the read
        raw = 3'h1;
        tick(2);
        host_u.read(CSI_CHAN_B_STATUS_ADDR, v);
        check(v, 8'h41);
        host_u.read(CSI_CHAN_B_STATUS_ADDR, v);
        check(v, 8'h49);
        raw = 3'h0;
        tick(5);
    endtask : test_flags

    // Soft reset with a latched flag pending and a write arriving while it runs
    task automatic test_soft_reset();
        logic [7:0] v;
        bit done;
        host_u.write(CSI_INDICATOR_ADDR, 8'hff, 1'b0);
        rx_status = '1;
        raw = 3'h1;
        tick(5);
        raw = 3'h0;
        tick(5);
        host_u.write(CSI_CHAN_B_STATUS_ADDR, 8'h80, 1'b1);
        check({5'h0, soft_reset, queue_flush, engine_on}, 8'h06);
        host_u.write(CSI_CHAN_B_STATUS_ADDR, 8'h40, 1'b1);
        check(8'(queue_flush), 8'h01);
        host_u.wait_reset_done(done);
        check(8'(done), 8'h01);
        check(8'(queue_flush), 8'h00);
        host_u.read(CSI_CHAN_B_STATUS_ADDR, v);
        check(v, 8'h00);
        host_u.read(CSI_INDICATOR_ADDR, v);
        check(v, 8'h0f);
        check(8'(pins), 8'h03);
        check(8'(status_irq), 8'h00);
    endtask : test_soft_reset

    // Low enable freezes registers, pins and latches
    task automatic test_freeze();
        logic [7:0] v;
        clk_en = 1'b0;
        host_u.write(CSI_INDICATOR_ADDR, 8'hf0, 1'b0);
        raw = 3'h4;
        tick(4);
        check({pins, 3'h0, status_irq}, 8'h30);
        clk_en = 1'b1;
        host_u.read(CSI_INDICATOR_ADDR, v);
        check(v, 8'h0f);
        tick(2);
        host_u.read(CSI_CHAN_B_STATUS_ADDR, v);
        check(v, 8'h24);
        raw = 3'h0;
    endtask : test_freeze

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rstn = 1'b0;
        clk_en = 1'b1;
        raw = 3'h0;
        rx_status = '0;
        repeat (12) @(posedge clk);
        #1;
        rstn = 1'b1;
        tick(1);
        test_reset_values();
        test_pins();
        test_flags();
        test_soft_reset();
        test_freeze();
        stop_test();
    end

    // Whole run needs under 3000 cycles
    initial begin
        #200000;
        num_errors++;
        stop_test();
    end
endmodule : csi_status_indicator_tb

// >>> logic/csi_flag_latch.sv
// Clear-on-read latch of one live fault flag
`timescale 1ns/10ps
module csi_flag_latch
    import csi_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    // Flag in, clears in
    input wire logic live,
    input wire logic read_clear,
    input wire logic soft_clear,
    // Latched copy
    output logic latched,
    output logic rise
);

    typedef struct packed {
        logic prev;
        logic latched;
    } csi_flag_state_s;

    csi_flag_state_s state;
    csi_flag_state_s next_state;

    assign rise = live & ~state.prev;
    assign latched = state.latched;

    always_comb begin
        next_state = state;
        next_state.prev = live;
        // A rising edge beats a read in the same cycle; soft reset beats both
        if (soft_clear) begin
            next_state.latched = 1'b0;
        end else if (rise) begin
            next_state.latched = 1'b1;
        end else if (read_clear) begin
            next_state.latched = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= '0;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

endmodule : csi_flag_latch

// >>> logic/csi_pkg.sv
// Shared constants and carriers for the channel status and indicator pin block
package csi_pkg;

    // Register offsets
    localparam logic [7:0] CSI_CHAN_B_STATUS_ADDR = 8'h0d;
    localparam logic [7:0] CSI_INDICATOR_ADDR = 8'h0e;

    // Channel B status/control fields
    localparam int CSI_BIT_SOFT_RESET = 7;
    localparam int CSI_BIT_ENGINE_ON = 6;
    localparam int CSI_LATCHED_LSB = 3;
    localparam int CSI_LIVE_LSB = 0;

    // Flag index inside the three-bit fault vectors
    localparam int CSI_FLAG_OVERCURRENT = 2;
    localparam int CSI_FLAG_UNDERVOLT = 1;
    localparam int CSI_FLAG_LINE_FAULT = 0;
    localparam int CSI_NUM_FLAGS = 3;

    // Indicator pin control fields
    localparam int CSI_BIT_B_SECOND_LAMP = 7;
    localparam int CSI_BIT_B_ERROR_SEL = 6;
    localparam int CSI_BIT_B_FIRST_LAMP = 5;
    localparam int CSI_BIT_B_READY_SEL = 4;
    localparam int CSI_BIT_A_SECOND_LAMP = 3;
    localparam int CSI_BIT_A_ERROR_SEL = 2;
    localparam int CSI_BIT_A_FIRST_LAMP = 1;
    localparam int CSI_BIT_A_READY_SEL = 0;

    // Reset values
    localparam logic [7:0] CSI_INDICATOR_RESET = 8'h00;
    localparam logic [7:0] CSI_CHAN_B_INDICATOR_MASK = 8'hf0;
    localparam logic [7:0] CSI_UNMAPPED_READ = 8'h00;
    localparam logic [2:0] CSI_FLAGS_RESET = 3'h0;

    // Soft reset duration
    localparam int CSI_CLK_PERIOD_NS = 10;
    localparam int CSI_SOFT_RESET_NS = 20;
    localparam int CSI_SOFT_RESET_CYCLES_INT = (CSI_SOFT_RESET_NS + CSI_CLK_PERIOD_NS - 1) / CSI_CLK_PERIOD_NS;
    localparam logic [1:0] CSI_SOFT_RESET_CYCLES = 2'(CSI_SOFT_RESET_CYCLES_INT);

    typedef enum logic [1:0] {
        CSI_SR_IDLE = 2'b00,
        CSI_SR_CLEAR = 2'b01
    } csi_sr_state_e;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csi_reg_req_s;

    // Receive status from the framers, same clock
    typedef struct packed {
        logic chan_b_receive_fault_status;
        logic chan_b_receive_data_ready_status;
        logic chan_a_receive_fault_status;
        logic chan_a_receive_data_ready_status;
    } csi_rx_status_s;

    // Multipurpose indicator pins, high = asserted / lamp on
    typedef struct packed {
        logic chan_b_error_or_lamp_pin;
        logic chan_b_ready_or_lamp_pin;
        logic chan_a_error_or_lamp_pin;
        logic chan_a_ready_or_lamp_pin;
    } csi_pins_s;

endpackage : csi_pkg

// >>> logic/csi_status_indicator.sv
// Channel B status/control register and indicator pin control register
// How it works
// - Writing one to soft reset clears channel B register bits and flushes the channel B queue.
// - Soft reset bit clears itself once the channel B reset is finished.
// - Soft reset leaves channel A bits and global bits untouched.
// - Engine-on bit hands the channel to internal engine; clear means external serial pins.
// - Latched overcurrent sets when live overcurrent rises from zero to one.
// - Latched undervoltage sets only on a rising live undervoltage flag.
// - Latched line fault sets only on a rising live line fault flag.
// - Latched flags are read-only and clear on read; other bits unchanged by reads.
// - Any set latched flag requests the global status interrupt.
// - Live overcurrent follows the supply current-limit detector.
// - Live undervoltage follows the undervoltage comparator.
// - Live line fault follows the line driver fault detector.
// - Channel B error select routes receive fault to pin, else lamp driver.
// - Channel B error pin ignores the receive fault interrupt mask.
// - Channel B second lamp bit drives pin only while error select is zero.
// - Channel B ready select routes data ready to pin, else lamp driver.
// - Channel B ready pin ignores the data ready interrupt mask.
// - Channel B first lamp bit drives pin only while ready select is zero.
// - Channel A second lamp bit drives pin only while error select is zero.
// - Channel A error select routes receive fault to pin, else lamp driver.
// - Channel A ready select routes data ready to pin, else first lamp bit.
`timescale 1ns/10ps
module csi_status_indicator
    import csi_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    // Register port
    input wire csi_reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    // Supply and line detectors, asynchronous
    input wire logic chan_b_supply_overcurrent_raw,
    input wire logic chan_b_supply_undervolt_raw,
    input wire logic chan_b_line_fault_raw,
    // Receive status from the framers
    input wire csi_rx_status_s rx_status,
    // Channel B control outputs
    output logic chan_b_message_engine_on,
    output logic chan_b_queue_flush,
    output logic chan_b_soft_reset,
    output logic global_status_irq,
    // Indicator pins
    output csi_pins_s pins
);

    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        csi_sr_state_e sr_state;
        logic [1:0] sr_count;
        logic engine_on;
        logic [7:0] indicator;
        logic [7:0] rdata;
        csi_pins_s pins;
    } csi_state_s;

    csi_state_s state;
    csi_state_s next_state;

    logic [2:0] live;
    logic [2:0] latched;
    logic [2:0] rise;
    logic status_read;
    logic status_write;
    logic indicator_write;
    logic resetting;

    assign live = state.sync2;
    assign status_read = reg_req.rd && (reg_req.addr == CSI_CHAN_B_STATUS_ADDR);
    assign status_write = reg_req.wr && (reg_req.addr == CSI_CHAN_B_STATUS_ADDR);
    assign indicator_write = reg_req.wr && (reg_req.addr == CSI_INDICATOR_ADDR);
    assign resetting = (state.sr_state == CSI_SR_CLEAR);

    // One latch per fault flag
    genvar gi;
    generate
        for (gi = 0; gi < CSI_NUM_FLAGS; gi++) begin : g_flag
            csi_flag_latch u_latch (
                .clk(clk),
                .rstn(rstn),
                .clk_en(clk_en),
                .live(live[gi]),
                .read_clear(status_read),
                .soft_clear(resetting),
                .latched(latched[gi]),
                .rise(rise[gi])
            );
        end
    endgenerate

    assign reg_rdata = state.rdata;
    assign chan_b_message_engine_on = state.engine_on;
    assign chan_b_queue_flush = resetting;
    assign chan_b_soft_reset = resetting;
    assign global_status_irq = |latched;
    assign pins = state.pins;

    always_comb begin
        next_state = state;
        // Detector inputs cross in from the analog side
        next_state.sync1 = {chan_b_supply_overcurrent_raw, chan_b_supply_undervolt_raw, chan_b_line_fault_raw};
        next_state.sync2 = state.sync1;

        // Register writes
        if (indicator_write) begin
            next_state.indicator = reg_req.wdata;
        end
        unique case (state.sr_state)
            CSI_SR_IDLE: begin
                if (status_write && reg_req.wdata[CSI_BIT_SOFT_RESET]) begin
                    next_state.sr_state = CSI_SR_CLEAR;
                    next_state.sr_count = CSI_SOFT_RESET_CYCLES - 2'd1;
                    next_state.engine_on = 1'b0;
                end else if (status_write) begin
                    next_state.engine_on = reg_req.wdata[CSI_BIT_ENGINE_ON];
                end
            end
            CSI_SR_CLEAR: begin
                // Writes to the status register are dropped while the reset runs
                next_state.engine_on = 1'b0;
                // Only the channel B half of the indicator register is reset
                next_state.indicator = (next_state.indicator & ~CSI_CHAN_B_INDICATOR_MASK) |
                                       (CSI_INDICATOR_RESET & CSI_CHAN_B_INDICATOR_MASK);
                if (state.sr_count == 2'd0) begin
                    next_state.sr_state = CSI_SR_IDLE;
                end else begin
                    next_state.sr_count = state.sr_count - 2'd1;
                end
            end
            // Unused codes fall back to idle rather than lock the channel
            default: begin
                next_state.sr_state = CSI_SR_IDLE;
            end
        endcase

        // Read data; reads never touch control or live bits
        if (reg_req.rd) begin
            if (status_read) begin
                next_state.rdata = {resetting, state.engine_on, latched, live};
            end else if (reg_req.addr == CSI_INDICATOR_ADDR) begin
                next_state.rdata = state.indicator;
            end else begin
                next_state.rdata = CSI_UNMAPPED_READ;
            end
        end

        // Pin muxes; interrupt masks are not consulted on purpose
        next_state.pins.chan_b_error_or_lamp_pin = state.indicator[CSI_BIT_B_ERROR_SEL] ?
            rx_status.chan_b_receive_fault_status : state.indicator[CSI_BIT_B_SECOND_LAMP];
        next_state.pins.chan_b_ready_or_lamp_pin = state.indicator[CSI_BIT_B_READY_SEL] ?
            rx_status.chan_b_receive_data_ready_status : state.indicator[CSI_BIT_B_FIRST_LAMP];
        next_state.pins.chan_a_error_or_lamp_pin = state.indicator[CSI_BIT_A_ERROR_SEL] ?
            rx_status.chan_a_receive_fault_status : state.indicator[CSI_BIT_A_SECOND_LAMP];
        next_state.pins.chan_a_ready_or_lamp_pin = state.indicator[CSI_BIT_A_READY_SEL] ?
            rx_status.chan_a_receive_data_ready_status : state.indicator[CSI_BIT_A_FIRST_LAMP];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= '{sync1: '0, sync2: '0, sr_state: CSI_SR_IDLE, sr_count: '0, engine_on: 1'b0,
                       indicator: CSI_INDICATOR_RESET, rdata: '0, pins: '0};
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // Checks run on enabled edges only, except c_freeze_write on every edge, since a low enable freezes everything
    a_sr_flush_start: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        (status_write && reg_req.wdata[CSI_BIT_SOFT_RESET] && !resetting)
        |=> chan_b_queue_flush ##1 (latched == 3'b000))
        else $error("soft reset did not start a flush");

    a_sr_self_clear: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        $rose(chan_b_soft_reset) |-> chan_b_soft_reset [*2] ##1 !chan_b_soft_reset)
        else $error("soft reset bit did not clear itself after two cycles");

    a_sr_keeps_a: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        (resetting && !indicator_write) |=> state.indicator[3:0] == $past(state.indicator[3:0]))
        else $error("channel A indicator bits changed during channel B reset");

    a_engine_write: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        (status_write && !reg_req.wdata[CSI_BIT_SOFT_RESET] && !resetting)
        |=> chan_b_message_engine_on == $past(reg_req.wdata[CSI_BIT_ENGINE_ON]))
        else $error("engine enable did not follow the write");

    a_overcurrent_latch: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        ($rose(live[CSI_FLAG_OVERCURRENT]) && !resetting) |=> latched[CSI_FLAG_OVERCURRENT] && global_status_irq)
        else $error("overcurrent rise not latched");

    a_undervolt_latch: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        (!latched[CSI_FLAG_UNDERVOLT] && !$rose(live[CSI_FLAG_UNDERVOLT])) |=> !latched[CSI_FLAG_UNDERVOLT])
        else $error("undervoltage latch set without a rising edge");

    a_line_fault_latch: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        ($rose(live[CSI_FLAG_LINE_FAULT]) && !resetting) |=> latched[CSI_FLAG_LINE_FAULT])
        else $error("line fault rise not latched");

    a_read_clears: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        (status_read && rise == 3'b000) |=> latched == 3'b000 && reg_rdata[5:3] == $past(latched))
        else $error("latched flags not returned and cleared by read");

    a_read_keeps_ctrl: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        (status_read && !reg_req.wr && !resetting) |=> $stable(chan_b_message_engine_on))
        else $error("read changed a control bit");

    a_live_readback: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        status_read |=> reg_rdata[2:0] == $past(live))
        else $error("live flags wrong in read data");

    a_read_race: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        (status_read && rise[CSI_FLAG_OVERCURRENT] && !resetting) |=> latched[CSI_FLAG_OVERCURRENT])
        else $error("flag rising during read was lost");

    a_b_error_pin: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        (state.indicator[CSI_BIT_B_ERROR_SEL] && rx_status.chan_b_receive_fault_status)
        |=> pins.chan_b_error_or_lamp_pin)
        else $error("channel B error pin not asserted");

    a_b_ready_lamp: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        !state.indicator[CSI_BIT_B_READY_SEL]
        |=> pins.chan_b_ready_or_lamp_pin == $past(state.indicator[CSI_BIT_B_FIRST_LAMP]))
        else $error("channel B first lamp not following its bit");

    a_a_ready_pin: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        state.indicator[CSI_BIT_A_READY_SEL]
        |=> pins.chan_a_ready_or_lamp_pin == $past(rx_status.chan_a_receive_data_ready_status))
        else $error("channel A ready pin not following data ready");

    // Raw flags need two enabled edges before the live bits see them
    a_live_overcurrent: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        live[CSI_FLAG_OVERCURRENT] == $past(chan_b_supply_overcurrent_raw, 2))
        else $error("live overcurrent lag wrong");

    a_live_undervolt: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        live[CSI_FLAG_UNDERVOLT] == $past(chan_b_supply_undervolt_raw, 2))
        else $error("live undervoltage lag wrong");

    a_live_line_fault: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        live[CSI_FLAG_LINE_FAULT] == $past(chan_b_line_fault_raw, 2))
        else $error("live line fault lag wrong");

    a_overcurrent_only_rise: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        (!latched[CSI_FLAG_OVERCURRENT] && !$rose(live[CSI_FLAG_OVERCURRENT])) |=> !latched[CSI_FLAG_OVERCURRENT])
        else $error("overcurrent latch set without rise");

    a_undervolt_rise_sets: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        ($rose(live[CSI_FLAG_UNDERVOLT]) && !resetting) |=> latched[CSI_FLAG_UNDERVOLT])
        else $error("undervoltage rise not latched");

    a_line_fault_only_rise: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        (!latched[CSI_FLAG_LINE_FAULT] && !$rose(live[CSI_FLAG_LINE_FAULT])) |=> !latched[CSI_FLAG_LINE_FAULT])
        else $error("line fault latch set without rise");

    // Pins are registered, so they answer the previous cycle
    a_b_error_follows: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        state.indicator[CSI_BIT_B_ERROR_SEL]
        |=> pins.chan_b_error_or_lamp_pin == $past(rx_status.chan_b_receive_fault_status))
        else $error("channel B error pin wrong");

    a_b_error_lamp: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        !state.indicator[CSI_BIT_B_ERROR_SEL]
        |=> pins.chan_b_error_or_lamp_pin == $past(state.indicator[CSI_BIT_B_SECOND_LAMP]))
        else $error("channel B second lamp wrong");

    a_b_ready_pin: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        state.indicator[CSI_BIT_B_READY_SEL]
        |=> pins.chan_b_ready_or_lamp_pin == $past(rx_status.chan_b_receive_data_ready_status))
        else $error("channel B ready pin wrong");

    a_a_error_lamp: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        !state.indicator[CSI_BIT_A_ERROR_SEL]
        |=> pins.chan_a_error_or_lamp_pin == $past(state.indicator[CSI_BIT_A_SECOND_LAMP]))
        else $error("channel A second lamp wrong");

    a_a_error_pin: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        state.indicator[CSI_BIT_A_ERROR_SEL]
        |=> pins.chan_a_error_or_lamp_pin == $past(rx_status.chan_a_receive_fault_status))
        else $error("channel A error pin wrong");

    a_a_ready_lamp: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        !state.indicator[CSI_BIT_A_READY_SEL]
        |=> pins.chan_a_ready_or_lamp_pin == $past(state.indicator[CSI_BIT_A_FIRST_LAMP]))
        else $error("channel A first lamp wrong");

    a_engine_hold: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        (!status_write && !resetting) |=> $stable(chan_b_message_engine_on))
        else $error("engine bit moved without a write");

    a_sr_engine_off: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        chan_b_soft_reset |-> !chan_b_message_engine_on)
        else $error("engine on during soft reset");

    a_sr_b_half: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        chan_b_soft_reset
        |=> (state.indicator & CSI_CHAN_B_INDICATOR_MASK) == (CSI_INDICATOR_RESET & CSI_CHAN_B_INDICATOR_MASK))
        else $error("channel B indicator half not reset");

    a_sr_flags_clear: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        chan_b_soft_reset |=> latched == 3'b000)
        else $error("latched flags survived soft reset");

    a_sr_write_dropped: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        (status_write && resetting) |=> !chan_b_message_engine_on)
        else $error("status write taken during soft reset");

    a_sr_read_busy: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        status_read |=> reg_rdata[CSI_BIT_SOFT_RESET] == $past(chan_b_soft_reset))
        else $error("soft reset bit read wrong");

    a_race_all_flags: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        (status_read && !resetting) |=> (latched & $past(rise)) == $past(rise))
        else $error("rise during read lost");

    a_read_keeps_indicator: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        (status_read && !indicator_write && !resetting) |=> $stable(state.indicator))
        else $error("read changed the indicator bits");

    a_irq_on_rise: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        (rise != 3'b000 && !resetting) |=> global_status_irq)
        else $error("rise did not raise the interrupt");

    a_irq_read_clear: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        (status_read && rise == 3'b000 && !resetting) |=> !global_status_irq)
        else $error("interrupt stayed after read");

    a_indicator_write: assert property (@(posedge clk iff clk_en) disable iff (!rstn)
        (indicator_write && !resetting) |=> state.indicator == $past(reg_req.wdata))
        else $error("indicator write not taken");

    c_soft_reset_done: cover property (@(posedge clk iff clk_en) disable iff (!rstn)
        $fell(chan_b_soft_reset));
    c_read_latched: cover property (@(posedge clk iff clk_en) disable iff (!rstn)
        status_read && latched != 3'b000);
    c_read_race: cover property (@(posedge clk iff clk_en) disable iff (!rstn)
        status_read && rise != 3'b000);
    c_ready_mode: cover property (@(posedge clk iff clk_en) disable iff (!rstn)
        state.indicator[CSI_BIT_B_READY_SEL] && pins.chan_b_ready_or_lamp_pin);
    c_freeze_write: cover property (@(posedge clk) disable iff (!rstn)
        !clk_en && reg_req.wr);

endmodule : csi_status_indicator
